//--- rtl/wdt_defines.svh
// timing constants for the watchdog timer
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH
// system clock period in ns
`define WDT_CLK_PERIOD_NS 20
// reset window after the interrupt timeout, in system clocks
`define WDT_RESET_WINDOW_CYC 512
// interval exponents per select code
`define WDT_EXP_SEL0 15
`define WDT_EXP_SEL1 18
`define WDT_EXP_SEL2 21
`define WDT_EXP_SEL3 24
// counter width, covers 2^24 plus reset window
`define WDT_CNT_W 25
// reset pulse length in system clocks
`define WDT_RST_PULSE_CYC 4
`endif

//--- rtl/wdt_pkg.sv
// types for the watchdog timer
package wdt_pkg;
	typedef enum logic [1:0] {
		WDT_ST_COUNT,
		WDT_ST_WINDOW,
		WDT_ST_RESET
	} wdt_state_e;

	typedef struct packed {
		logic       enable;
		logic       irq_enable;
		logic [1:0] timeout_interval_select;
	} wdt_cfg_s;

	typedef struct packed {
		wdt_state_e  st;
		logic [24:0] cnt;
		logic [2:0]  rst_cnt;
		logic        restart_s1;
		logic        restart_s2;
		logic        restart_s3;
		logic        irq;
		logic        timeout_pulse;
		logic        sys_reset;
	} wdt_state_s;
endpackage : wdt_pkg

//--- rtl/wdt_watchdog.sv
// watchdog timer: interval timeout, interrupt and system reset
`timescale 1ns/1ns
`include "wdt_defines.svh"

module wdt_watchdog
	import wdt_pkg::*;
(
	// clock and reset
	input  wire logic     clk_sys,
	input  wire logic     reset,
	// configuration and software restart
	input  wire wdt_cfg_s cfg,
	input  wire logic     restart,
	// events
	output logic          wdt_irq,
	output logic          wdt_timeout,
	output logic          wdt_sys_reset
);

	localparam int CW = `WDT_CNT_W;

	wdt_state_s q;
	wdt_state_s d;
	logic [CW-1:0] interval;
	logic          restart_rise;

	// ==========================================================
	// interval decode
	always_comb begin
		case (cfg.timeout_interval_select)
			2'h0:    interval = CW'(1) << `WDT_EXP_SEL0;
			2'h1:    interval = CW'(1) << `WDT_EXP_SEL1;
			2'h2:    interval = CW'(1) << `WDT_EXP_SEL2;
			2'h3:    interval = CW'(1) << `WDT_EXP_SEL3;
			default: interval = CW'(1) << `WDT_EXP_SEL3;
		endcase
	end

	// ==========================================================
	// next state
	assign restart_rise = q.restart_s2 & ~q.restart_s3;

	always_comb begin
		d               = q;
		d.restart_s1    = restart;
		d.restart_s2    = q.restart_s1;
		d.restart_s3    = q.restart_s2;
		d.timeout_pulse = 1'b0;
		d.sys_reset     = 1'b0;
		if (!cfg.enable) begin
			d.st  = WDT_ST_COUNT;
			d.cnt = '0;
			d.irq = 1'b0;
		end else begin
			case (q.st)
				WDT_ST_COUNT: begin
					if (restart_rise) begin
						d.cnt = '0;
					end else if (q.cnt == interval - CW'(1)) begin
						d.cnt           = q.cnt + CW'(1);
						d.st            = WDT_ST_WINDOW;
						d.timeout_pulse = 1'b1;
						d.irq           = cfg.irq_enable;
					end else begin
						d.cnt = q.cnt + CW'(1);
					end
				end
				WDT_ST_WINDOW: begin
					if (restart_rise) begin
						d.cnt = '0;
						d.irq = 1'b0;
						d.st  = WDT_ST_COUNT;
					end else if (q.cnt == interval + CW'(`WDT_RESET_WINDOW_CYC - 1)) begin
						d.cnt       = '0;
						d.st        = WDT_ST_RESET;
						d.sys_reset = 1'b1;
						d.rst_cnt   = 3'(`WDT_RST_PULSE_CYC - 1);
						d.irq       = 1'b0;
					end else begin
						d.cnt = q.cnt + CW'(1);
					end
				end
				WDT_ST_RESET: begin
					d.cnt = '0;
					if (q.rst_cnt == 3'h0) begin
						d.st = WDT_ST_COUNT;
					end else begin
						d.sys_reset = 1'b1;
						d.rst_cnt   = q.rst_cnt - 3'h1;
					end
				end
				default: begin
					d.st  = WDT_ST_COUNT;
					d.cnt = '0;
				end
			endcase
		end
		if (!cfg.irq_enable) begin
			d.irq = 1'b0;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= '{st: WDT_ST_COUNT, default: '0};
		end else begin
			q <= d;
		end
	end

	assign wdt_irq       = q.irq;
	assign wdt_timeout   = q.timeout_pulse;
	assign wdt_sys_reset = q.sys_reset;

endmodule : wdt_watchdog

//--- tb/wdt_assertions.sv
// watchdog event checks
`timescale 1ns/1ns
module wdt_chk
	import wdt_pkg::*;
(
	// clock, reset
	input wire logic     clk_sys,
	input wire logic     reset,
	// controls
	input wire wdt_cfg_s cfg,
	input wire logic     restart,
	// events
	input wire logic     wdt_irq,
	input wire logic     wdt_timeout,
	input wire logic     wdt_sys_reset
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// ====
	// assertions
	a_pulse_one: assert property (wdt_timeout |=> !wdt_timeout) else $error("to");
	a_irq_cause: assert property ($rose(wdt_irq) |-> wdt_timeout) else $error("ic");
	a_irq_gate: assert property (!cfg.irq_enable |=> !wdt_irq) else $error("ig");
	a_rst_len: assert property ($rose(wdt_sys_reset) |-> wdt_sys_reset[*4] ##1 !wdt_sys_reset)
		else $error("rl");
	a_rst_delay: assert property ($rose(wdt_sys_reset) |-> $past(wdt_timeout, 512))
		else $error("rd");
	a_off_quiet: assert property (!cfg.enable |=> !(wdt_timeout | wdt_sys_reset | wdt_irq))
		else $error("oq");
	a_rst_irq: assert property ($rose(wdt_sys_reset) |-> !wdt_irq) else $error("ri");
	a_rst_no_to: assert property (wdt_sys_reset |-> !wdt_timeout) else $error("rt");
	c_to: cover property (wdt_timeout);
	c_rst: cover property ($rose(wdt_sys_reset));
	c_cancel: cover property ($fell(wdt_irq) && !wdt_sys_reset);
endmodule : wdt_chk
bind wdt_watchdog wdt_chk u_chk (.*);

//--- tb/testbench.sv
// self-checking bench for the watchdog timer
`timescale 1ns/1ns
module testbench;
	import wdt_pkg::*;
	logic     clk_sys = 0, reset = 1, restart = 0;
	wdt_cfg_s cfg = '0;
	logic     wdt_irq, wdt_timeout, wdt_sys_reset;
	int       n_fail = 0, num_checks = 0, n;
	wdt_watchdog uut (.clk_sys(clk_sys), .reset(reset), .cfg(cfg), .restart(restart),
		.wdt_irq(wdt_irq), .wdt_timeout(wdt_timeout), .wdt_sys_reset(wdt_sys_reset));
	initial forever #10 clk_sys = ~clk_sys;
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	// count edges until s is high, bounded
	task automatic wt(ref logic s, input int lim, input bit must);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
		if (must && n >= lim) begin
			n_fail++;
			report_and_stop();
		end
	endtask : wt
	task automatic pulse;
		@(posedge clk_sys);
		restart <= 1;
		@(posedge clk_sys);
		restart <= 0;
	endtask : pulse
	// serviced, then timeout without irq, then cancel in window
	task automatic t_quiet;
		cfg <= '{1'b1, 1'b0, 2'b00};
		repeat (300) @(posedge clk_sys);
		pulse();
		wt(wdt_timeout, 40000, 1);
		chk(n > 32760 && n < 32780, 1);
		chk(wdt_irq, 0);
		pulse();
		wt(wdt_sys_reset, 700, 0);
		chk(n, 700);
		$display("t_quiet done");
	endtask : t_quiet
	// full timeout with irq, then reset 512 later
	task automatic t_fire;
		@(posedge clk_sys);
		cfg <= '{1'b1, 1'b1, 2'b00};
		pulse();
		wt(wdt_timeout, 40000, 1);
		chk(wdt_irq, 1);
		wt(wdt_sys_reset, 700, 1);
		chk(n, 512);
		chk(wdt_irq, 0);
		$display("t_fire done");
	endtask : t_fire
	// select 01 outlasts the shortest interval
	task automatic t_long;
		@(posedge clk_sys);
		cfg <= '{1'b1, 1'b1, 2'b01};
		pulse();
		wt(wdt_timeout, 32800, 0);
		chk(n, 32800);
		$display("t_long done");
	endtask : t_long
	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 0;
		@(posedge clk_sys);
		t_quiet();
		t_fire();
		t_long();
		report_and_stop();
	end
endmodule : testbench
